// ---- include/updown_timer_pkg.sv ----
// Constants shared by the up/down auto-reload timer.
package updown_timer_pkg;
  localparam logic [7:0] mode_reg_addr = 8'hc9;
  localparam int prescale_div = 12;
  localparam logic [15:0] count_all_ones = 16'hffff;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [7:0] byte_ones = 8'hff;
  localparam int mode_bit_up_down = 0;
  localparam int mode_bit_clock_out = 1;
  typedef enum logic [1:0] {
    mode_capture,
    mode_auto_reload,
    mode_baud_gen
  } timer_mode_type;
endpackage

// ---- design/pin_sync.sv ----
// Two-stage synchroniser with a combinational falling-edge detector on registered levels.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pin and results
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic stage1;
  logic stage2;
  logic prev;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      prev <= 1'b1;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      prev <= stage2;
    end
  end

  assign level = stage2;
  assign fall = prev & ~stage2;
endmodule

// ---- design/updown_reload_timer.sv ----
// Third timer/counter with capture, auto-reload, up/down and baud modes.
`timescale 1ns/1ps
module updown_reload_timer #(
  parameter int divide = updown_timer_pkg::prescale_div
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pins
  input wire logic count_input_pin,
  input wire logic direction_pin,
  // Control bits
  input wire logic run_bit,
  input wire logic timer_counter_select,
  input wire logic capture_reload_select,
  input wire logic rx_clock_select,
  input wire logic tx_clock_select,
  input wire logic ext_enable,
  input wire logic up_down_enable,
  input wire logic irq_enable,
  // Software writes
  input wire logic count_low_we,
  input wire logic count_high_we,
  input wire logic reload_low_we,
  input wire logic reload_high_we,
  input wire logic [7:0] write_data,
  input wire logic overflow_flag_clear,
  input wire logic external_flag_clear,
  // Status
  output logic [7:0] count_low_byte,
  output logic [7:0] count_high_byte,
  output logic [7:0] reload_low_byte,
  output logic [7:0] reload_high_byte,
  output logic overflow_flag,
  output logic external_flag,
  output logic irq_request,
  output logic baud_tick,
  output logic [1:0] active_mode
);
  // The prescaler is eight bits wide and must see at least two phases.
  if (divide < 2 || divide > 255) begin : gen_bad_divide
    $error("divide out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  logic dir_level;
  logic cnt_fall;
  logic dir_fall;
  logic [7:0] prescale;
  logic tick;
  logic [15:0] count;
  logic serial_mode;
  logic updown;
  logic count_up;
  logic wrap_up;
  logic underflow;
  logic ext_event;
  logic set_ovf;
  logic toggle_ext;
  logic set_ext;
  updown_timer_pkg::timer_mode_type mode;

  pin_sync count_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin(count_input_pin),
    .level(),
    .fall(cnt_fall)
  );
  pin_sync dir_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin(direction_pin),
    .level(dir_level),
    .fall(dir_fall)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 8'h00;
    end else if (prescale == 8'(divide - 1)) begin
      prescale <= 8'h00;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  assign tick = run_bit & (timer_counter_select ? cnt_fall : (prescale == 8'(divide - 1)));

  assign serial_mode = rx_clock_select | tx_clock_select;
  always_comb begin
    if (serial_mode) begin
      mode = updown_timer_pkg::mode_baud_gen;
    end else if (capture_reload_select) begin
      mode = updown_timer_pkg::mode_capture;
    end else begin
      mode = updown_timer_pkg::mode_auto_reload;
    end
  end

  assign updown = up_down_enable & (mode == updown_timer_pkg::mode_auto_reload);
  assign count_up = ~updown | dir_level;
  assign count = {count_high_byte, count_low_byte};
  assign wrap_up = tick & count_up & (count == updown_timer_pkg::count_all_ones);
  assign underflow = tick & ~count_up & (count == {reload_high_byte, reload_low_byte});
  assign ext_event = ext_enable & ~updown & ~serial_mode & dir_fall;
  assign set_ovf = (wrap_up | underflow) & ~serial_mode;
  assign toggle_ext = updown & (wrap_up | underflow);
  assign set_ext = ext_event;

  ////////////////////////////////////////////////////////////////////////
  // cascaded count bytes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_byte <= updown_timer_pkg::byte_reset;
      count_high_byte <= updown_timer_pkg::byte_reset;
    end else if (wrap_up && (mode != updown_timer_pkg::mode_capture)) begin
      count_low_byte <= reload_low_byte;
      count_high_byte <= reload_high_byte;
    end else if (underflow) begin
      count_low_byte <= updown_timer_pkg::byte_ones;
      count_high_byte <= updown_timer_pkg::byte_ones;
    end else if (ext_event && mode == updown_timer_pkg::mode_auto_reload) begin
      count_low_byte <= reload_low_byte;
      count_high_byte <= reload_high_byte;
    end else if (tick) begin
      if (count_up) begin
        {count_high_byte, count_low_byte} <= count + 16'h0001;
      end else begin
        {count_high_byte, count_low_byte} <= count - 16'h0001;
      end
    end else begin
      if (count_low_we) count_low_byte <= write_data;
      if (count_high_we) count_high_byte <= write_data;
    end
  end

  // Capture copies the count on a pin event; software writes otherwise.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_low_byte <= updown_timer_pkg::byte_reset;
      reload_high_byte <= updown_timer_pkg::byte_reset;
    end else if (ext_event && mode == updown_timer_pkg::mode_capture) begin
      reload_low_byte <= count_low_byte;
      reload_high_byte <= count_high_byte;
    end else begin
      if (reload_low_we) reload_low_byte <= write_data;
      if (reload_high_we) reload_high_byte <= write_data;
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (set_ovf) begin
      overflow_flag <= 1'b1;
    end else if (overflow_flag_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      external_flag <= 1'b0;
    end else if (toggle_ext) begin
      external_flag <= ~external_flag;
    end else if (set_ext) begin
      external_flag <= 1'b1;
    end else if (external_flag_clear) begin
      external_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
      baud_tick <= 1'b0;
      active_mode <= 2'h0;
    end else begin
      irq_request <= irq_enable & (overflow_flag | (external_flag & ~updown));
      baud_tick <= wrap_up & serial_mode;
      active_mode <= mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag after overflow
  chk_ovf_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrap_up && !serial_mode) |=> overflow_flag)
    else $error("overflow did not set flag");
  chk_up_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrap_up && mode == updown_timer_pkg::mode_auto_reload)
    |=> count == $past({reload_high_byte, reload_low_byte}))
    else $error("reload not loaded");
  chk_under_ones: assert property (@(posedge sys_clk) disable iff (!rst_n)
    underflow |=> count == updown_timer_pkg::count_all_ones && overflow_flag)
    else $error("underflow load wrong");
  chk_ext_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    toggle_ext |=> external_flag != $past(external_flag))
    else $error("external flag did not toggle");
  chk_serial_noflag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (serial_mode && !overflow_flag) |=> !overflow_flag)
    else $error("flag set in serial mode");
  chk_hold_stopped: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!run_bit && !count_low_we && !count_high_we && !ext_event) |=> $stable(count))
    else $error("count moved while stopped");
  chk_carry_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && count_up && !ext_event && count_low_byte == updown_timer_pkg::byte_ones
      && count_high_byte != updown_timer_pkg::byte_ones)
    |=> count_high_byte == $past(count_high_byte) + 8'h01)
    else $error("carry lost");
  chk_no_ext_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (updown && !overflow_flag) |=> !irq_request)
    else $error("external flag raised interrupt");
endmodule

// ---- sim/pin_partner.sv ----
// Model of the external count and direction pins.
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input wire logic sys_clk,
  // Pins
  output logic count_input_pin,
  output logic direction_pin
);
  initial begin
    count_input_pin = 1'b1;
    direction_pin = 1'b1;
  end
  // one falling edge
  // Each level is held four cycles so the synchroniser cannot miss it.
  task automatic fall_pulse();
    @(posedge sys_clk);
    count_input_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    count_input_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic set_dir(input logic up);
    @(posedge sys_clk);
    direction_pin <= up;
  endtask
endmodule

// ---- sim/updown_reload_timer_tb.sv ----
// Self-checking bench for the up/down auto-reload timer.
`timescale 1ns/1ps
module updown_reload_timer_tb;
  localparam int div = 4;
  logic sys_clk, rst_n, run_bit, tcs, crs, rcs, txc, ud;
  logic [5:0] strobe;
  logic [7:0] wd, cl, ch, rl, rh;
  logic ovf, ext, irq, bt;
  logic [1:0] mode;
  wire logic cin, dir;
  wire logic [15:0] cnt = {ch, cl};
  int bad_count, tests_run;
  pin_partner partner (.sys_clk(sys_clk), .count_input_pin(cin), .direction_pin(dir));
  updown_reload_timer #(.divide(div)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .count_input_pin(cin), .direction_pin(dir), .run_bit(run_bit),
    .timer_counter_select(tcs), .capture_reload_select(crs), .rx_clock_select(rcs),
    .tx_clock_select(txc), .ext_enable(1'b0), .up_down_enable(ud), .irq_enable(1'b1),
    .count_low_we(strobe[0]), .count_high_we(strobe[1]), .reload_low_we(strobe[2]),
    .reload_high_we(strobe[3]), .write_data(wd), .overflow_flag_clear(strobe[4]),
    .external_flag_clear(strobe[5]), .count_low_byte(cl), .count_high_byte(ch),
    .reload_low_byte(rl), .reload_high_byte(rh), .overflow_flag(ovf),
    .external_flag(ext), .irq_request(irq), .baud_tick(bt), .active_mode(mode));
  always #50 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  // Counts and reloads are loaded with the timer stopped, so no write is lost to a tick.
  // Both flags are cleared last; one more edge lets the final clear show on the outputs.
  task automatic load(input logic [15:0] c, input logic [15:0] r);
    logic [7:0] d [6] = '{c[7:0], c[15:8], r[7:0], r[15:8], 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      strobe <= 6'h01 << i;
      wd <= d[i];
      @(posedge sys_clk);
      strobe <= 6'h00;
    end
    @(posedge sys_clk);
  endtask
  task automatic wait_count(input logic [15:0] v);
    int i;
    i = 0;
    while (cnt !== v && i < 300) begin
      @(posedge sys_clk);
      i++;
    end
    check(cnt, v, "count");
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    final_report();
  end
  initial begin
    sys_clk = 0; rst_n = 0; run_bit = 0; tcs = 0; crs = 0; rcs = 0; txc = 0; ud = 0;
    strobe = 6'h00; wd = 8'h00; bad_count = 0; tests_run = 0;
    repeat (20) @(posedge sys_clk);
    check(cnt, updown_timer_pkg::count_reset, "reset count");
    check({rh, rl}, updown_timer_pkg::count_reset, "reset reload");
    check({mode, ovf, ext, irq}, 5'h00, "reset flags");
    rst_n <= 1'b1;
    load(16'h00fe, 16'h0000);
    run_bit <= 1'b1;
    repeat (div * 10) @(posedge sys_clk);
    check(cnt == 16'h0107 || cnt == 16'h0108, 1'b1, "carry and prescale");
    run_bit <= 1'b0;
    wait_count(16'h0108);
    repeat (20) @(posedge sys_clk);
    check(cnt, 16'h0108, "held");
    $display("end of prescale test");
    load(16'hfffe, 16'h1234);
    run_bit <= 1'b1;
    wait_count(16'h1234);
    repeat (2) @(posedge sys_clk);
    check({ovf, ext, irq, mode}, 5'b10101, "up overflow");
    run_bit <= 1'b0;
    $display("end of up test");
    ud <= 1'b1;
    partner.set_dir(1'b0);
    load(16'h1236, 16'h1234);
    run_bit <= 1'b1;
    wait_count(16'h1234);
    wait_count(16'hffff);
    repeat (2) @(posedge sys_clk);
    check({ovf, ext}, 2'b11, "underflow");
    run_bit <= 1'b0;
    load(16'h1235, 16'h1234);
    check({ovf, ext}, 2'b00, "software clear");
    run_bit <= 1'b1;
    wait_count(16'hffff);
    run_bit <= 1'b0;
    @(posedge sys_clk);
    strobe[4] <= 1'b1;
    @(posedge sys_clk);
    strobe <= 6'h00;
    repeat (3) @(posedge sys_clk);
    check({ovf, ext, irq}, 3'b010, "no flag irq");
    partner.set_dir(1'b1);
    run_bit <= 1'b1;
    wait_count(16'h1234);
    repeat (2) @(posedge sys_clk);
    check({ovf, ext}, 2'b10, "toggle back");
    run_bit <= 1'b0;
    ud <= 1'b0;
    tcs <= 1'b1;
    $display("end of up/down test");
    load(16'h0010, 16'h0000);
    run_bit <= 1'b1;
    repeat (3) partner.fall_pulse();
    check(cnt, 16'h0013, "pin count");
    run_bit <= 1'b0;
    partner.fall_pulse();
    check(cnt, 16'h0013, "stopped pin");
    $display("end of counter test");
    tcs <= 1'b0;
    rcs <= 1'b1;
    crs <= 1'b1;
    load(16'hfffe, 16'h4321);
    run_bit <= 1'b1;
    wait_count(16'h4321);
    check(bt, 1'b1, "receive baud tick");
    repeat (2) @(posedge sys_clk);
    check({ovf, mode, bt}, 4'b0100, "baud");
    run_bit <= 1'b0;
    rcs <= 1'b0;
    txc <= 1'b1;
    load(16'hfffe, 16'h5678);
    run_bit <= 1'b1;
    wait_count(16'h5678);
    check(bt, 1'b1, "transmit baud tick");
    repeat (2) @(posedge sys_clk);
    check({ovf, mode}, 3'b010, "transmit baud");
    $display("end of baud test");
    run_bit <= 1'b0;
    txc <= 1'b0;
    load(16'hfffe, 16'h4321);
    run_bit <= 1'b1;
    wait_count(16'h0000);
    repeat (2) @(posedge sys_clk);
    check({ovf, mode, bt}, 4'b1000, "capture wrap");
    $display("end of capture test");
    final_report();
  end
endmodule
